// *** common/dsp_cfg.svh ***
// Constants for the dual slot power register bank: command codes, bit positions, resets.
// Assumes inclusion by its bare name from the design file and the bench.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ----------------------------------------------------------------------------
// Command byte codes
// ----------------------------------------------------------------------------
`define DSP_CMD_CTL_A      8'h02
`define DSP_CMD_CTL_B      8'h03
`define DSP_CMD_STAT_A     8'h04
`define DSP_CMD_STAT_B     8'h05
`define DSP_CMD_COMMON     8'h06

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DSP_CTL_STANDBY_ON   0
`define DSP_CTL_PRIMARY_ON   1
`define DSP_CTL_OVR_GATE     2
`define DSP_CTL_PRIMARY_PG   6
`define DSP_CTL_STANDBY_PG   7
`define DSP_CTL_RESET        3'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define DSP_ST_THREE_OC      0
`define DSP_ST_TWELVE_OC     2
`define DSP_ST_STANDBY_OC    4
`define DSP_ST_STANDBY_ON    5
`define DSP_ST_PRIMARY_ON    6
`define DSP_ST_FAULT         7
`define DSP_ST_RESET         3'h0

// ----------------------------------------------------------------------------
// Common status register fields
// ----------------------------------------------------------------------------
`define DSP_CS_OT            1
`define DSP_CS_UV            2
`define DSP_CS_MASK          3
`define DSP_CS_GPI_A         4
`define DSP_CS_GPI_B         5
`define DSP_CS_MASK_RESET    1'h0

`endif

// *** common/dsp_pkg.sv ***
// Types for the dual slot power register bank.
// Assumes dsp_cfg.svh is on the include path.
package dsp_pkg;

  // --------------------------------------------------------------------------
  // Slot pin groups
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic standbyPg;
    logic primaryPg;
    logic overrideOnN;
    logic primaryOnPin;
    logic standbyEnablePin;
    logic standbyOc;
    logic twelveOc;
    logic threeOc;
  } dsp_slot_in_t;

  typedef struct packed {
    logic standbyPowerOn;
    logic primaryPowerOn;
    logic powerOkOut;
    logic powerOkOe;
    logic faultOut;
    logic faultOe;
  } dsp_slot_out_t;

  // Sticky overcurrent flags, in status bit order 4, 2, 0.
  typedef struct packed {
    logic standby;
    logic twelve;
    logic three;
  } dsp_oc_t;

endpackage

// *** design/dsp_regs.sv ***
// Dual slot power register bank: control, status and common status registers,
// slot pin logic, and the byte command port on the link clock.
// Assumes analog comparators and overcurrent detectors drive the slot inputs
// asynchronously, and that a serial front end on lnkClk presents whole bytes.
`timescale 1ns/1ns
`include "dsp_cfg.svh"

module dsp_regs #(
  parameter int NUM_SLOTS = 2
) (
  input  wire logic                           mclk,
  input  wire logic                           srst,
  input  wire logic                           ce,
  input  wire logic                           lnkClk,
  input  wire logic                           lnkRst,
  input  wire logic                           lnkCmdValid,
  input  wire logic                           lnkWrite,
  input  wire logic [7:0]                     lnkCmd,
  input  wire logic [7:0]                     lnkWdata,
  output logic                                lnkReady,
  output logic                                lnkDone,
  output logic [7:0]                          lnkRdata,
  input  wire dsp_pkg::dsp_slot_in_t          slotIn [NUM_SLOTS],
  output dsp_pkg::dsp_slot_out_t              slotOut [NUM_SLOTS],
  input  wire logic                           uvEvent,
  input  wire logic                           otEvent,
  input  wire logic [1:0]                     gpiIn,
  output logic                                attnOut,
  output logic                                attnOe
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    dsp_pkg::dsp_slot_in_t [NUM_SLOTS-1:0] in1;
    dsp_pkg::dsp_slot_in_t [NUM_SLOTS-1:0] in2;
    logic [3:0]                            com1;
    logic [3:0]                            com2;
    logic                                  req1;
    logic                                  req2;
    logic                                  req3;
    logic [NUM_SLOTS-1:0][2:0]             ctl;
    dsp_pkg::dsp_oc_t [NUM_SLOTS-1:0]      flg;
    logic [NUM_SLOTS-1:0]                  hpiMain;
    logic [NUM_SLOTS-1:0]                  hpiAux;
    logic                                  mask;
    logic                                  uvFlag;
    logic                                  otFlag;
    logic [7:0]                            rdData;
    logic                                  ackTgl;
  } dsp_core_t;

  typedef struct packed {
    logic       reqTgl;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic       busy;
    logic       ack1;
    logic       ack2;
    logic       ack3;
    logic       done;
    logic [7:0] rdata;
  } dsp_link_t;

  dsp_core_t core_ff;
  dsp_core_t nxt_core;
  dsp_link_t link_ff;
  dsp_link_t nxt_link;

  logic [NUM_SLOTS-1:0] forced;
  logic [NUM_SLOTS-1:0] powerGood;
  logic [NUM_SLOTS-1:0] primaryOn;
  logic [NUM_SLOTS-1:0] standbyOn;
  logic [NUM_SLOTS-1:0] faultActive;
  logic [NUM_SLOTS-1:0] overrideLow;
  logic                 anyFlag;
  logic                 access;

  // --------------------------------------------------------------------------
  // Register read mux
  // --------------------------------------------------------------------------
  function automatic logic [7:0] readReg(input dsp_core_t s, input logic [7:0] cmd,
                                         input logic [NUM_SLOTS-1:0] pOn,
                                         input logic [NUM_SLOTS-1:0] sOn,
                                         input logic [NUM_SLOTS-1:0] flt);
    logic [7:0] v;
    int         k;
    v = 8'h00;
    k = 0;
    case (cmd)
      `DSP_CMD_CTL_A, `DSP_CMD_CTL_B: begin
        k = (cmd == `DSP_CMD_CTL_B) ? 1 : 0;
        v[2:0] = s.ctl[k];
        v[`DSP_CTL_PRIMARY_PG] = s.in2[k].primaryPg;
        v[`DSP_CTL_STANDBY_PG] = s.in2[k].standbyPg;
      end
      `DSP_CMD_STAT_A, `DSP_CMD_STAT_B: begin
        k = (cmd == `DSP_CMD_STAT_B) ? 1 : 0;
        v[`DSP_ST_THREE_OC]   = s.flg[k].three;
        v[`DSP_ST_TWELVE_OC]  = s.flg[k].twelve;
        v[`DSP_ST_STANDBY_OC] = s.flg[k].standby;
        v[`DSP_ST_STANDBY_ON] = sOn[k];
        v[`DSP_ST_PRIMARY_ON] = pOn[k];
        v[`DSP_ST_FAULT]      = flt[k];
      end
      `DSP_CMD_COMMON: begin
        v[`DSP_CS_OT]    = s.otFlag;
        v[`DSP_CS_UV]    = s.uvFlag;
        v[`DSP_CS_MASK]  = s.mask;
        v[`DSP_CS_GPI_A] = s.com2[2];
        v[`DSP_CS_GPI_B] = s.com2[3];
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Slot pin logic
  // --------------------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      assign overrideLow[g] = ~core_ff.in2[g].overrideOnN;
      assign forced[g]      = overrideLow[g] & ~core_ff.ctl[g][`DSP_CTL_OVR_GATE];
      assign powerGood[g]   = core_ff.in2[g].standbyPg & core_ff.in2[g].primaryPg;
      // Unless forced, a tripped supply stays off until its flag is cleared by a status write (register path) or its enable pin is withdrawn (pin path).
      assign primaryOn[g]   = forced[g]
                            | (core_ff.ctl[g][`DSP_CTL_PRIMARY_ON]
                               & ~(core_ff.flg[g].twelve | core_ff.flg[g].three))
                            | (core_ff.in2[g].primaryOnPin & ~core_ff.hpiMain[g]);
      assign standbyOn[g]   = forced[g]
                            | (core_ff.ctl[g][`DSP_CTL_STANDBY_ON]
                               & ~core_ff.flg[g].standby)
                            | (core_ff.in2[g].standbyEnablePin & ~core_ff.hpiAux[g]);
      assign faultActive[g] = core_ff.hpiMain[g] | core_ff.hpiAux[g];

      always_comb begin
        slotOut[g].standbyPowerOn = standbyOn[g];
        slotOut[g].primaryPowerOn = primaryOn[g];
        slotOut[g].powerOkOut     = 1'b0;
        slotOut[g].powerOkOe      = forced[g] | ~powerGood[g];
        slotOut[g].faultOut       = 1'b0;
        slotOut[g].faultOe        = faultActive[g] & ~overrideLow[g];
      end

      a_pok_follows: assert property (@(posedge mclk) disable iff (srst)
        !forced[g] |-> (slotOut[g].powerOkOe == !(core_ff.in2[g].standbyPg
                                                 && core_ff.in2[g].primaryPg)))
        else $error("power ok pin does not follow power good bits");

      a_force_pok: assert property (@(posedge mclk) disable iff (srst)
        (overrideLow[g] && !core_ff.ctl[g][`DSP_CTL_OVR_GATE]) |-> slotOut[g].powerOkOe)
        else $error("override did not force power not good");

      a_fault_release: assert property (@(posedge mclk) disable iff (srst)
        overrideLow[g] |-> !slotOut[g].faultOe)
        else $error("fault pin driven while override low");

      a_fault_clears: assert property (@(posedge mclk) disable iff (srst || !ce)
        (!core_ff.in2[g].primaryOnPin && !core_ff.in2[g].standbyEnablePin)
          [*2] |-> !faultActive[g])
        else $error("fault latch held with both enable pins low");

      a_flag_sticky: assert property (@(posedge mclk) disable iff (srst)
        (ce && core_ff.flg[g].twelve && !(access && link_ff.wr)) |=> core_ff.flg[g].twelve)
        else $error("overcurrent flag lost without a clear");

      a_ctl_reset: assert property (@(posedge mclk)
        $fell(srst) |-> (core_ff.ctl[g] == `DSP_CTL_RESET
                         && core_ff.flg[g] == `DSP_ST_RESET && !primaryOn[g] | forced[g]))
        else $error("slot registers not cleared by reset");

      a_flag_sets: assert property (@(posedge mclk) disable iff (srst)
        (ce && core_ff.in2[g].twelveOc && core_ff.ctl[g][`DSP_CTL_PRIMARY_ON])
          |=> core_ff.flg[g].twelve)
        else $error("overcurrent flag not set while supply enabled");

      a_smi_no_fault: assert property (@(posedge mclk) disable iff (srst)
        (ce && !core_ff.in2[g].primaryOnPin && !core_ff.in2[g].standbyEnablePin)
          |=> !faultActive[g])
        else $error("fault latched under register control");

      a_latch_aux: assert property (@(posedge mclk) disable iff (srst)
        (ce && core_ff.in2[g].standbyOc && core_ff.in2[g].standbyEnablePin && !forced[g])
          |=> core_ff.hpiAux[g])
        else $error("standby overcurrent not latched at the fault pin");

      a_supply_off: assert property (@(posedge mclk) disable iff (srst)
        (!forced[g] && !core_ff.ctl[g][`DSP_CTL_PRIMARY_ON] && !core_ff.in2[g].primaryOnPin)
          |-> !slotOut[g].primaryPowerOn)
        else $error("primary supply on with every enable off");
    end
  endgenerate

  assign anyFlag = (|core_ff.flg) | core_ff.uvFlag | core_ff.otFlag;
  assign attnOut = 1'b0;
  assign attnOe  = anyFlag & ~core_ff.mask;
  assign access  = ce & (core_ff.req2 ^ core_ff.req3);

  // --------------------------------------------------------------------------
  // Core next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [7:0] clr;
    int         k;
    clr = 8'h00;
    k = 0;
    nxt_core = core_ff;
    // The pin stages are unpacked at the port and packed in the state word.
    for (int s = 0; s < NUM_SLOTS; s++) begin
      nxt_core.in1[s] = slotIn[s];
    end
    nxt_core.in2  = core_ff.in1;
    nxt_core.com1 = {gpiIn, otEvent, uvEvent};
    nxt_core.com2 = core_ff.com1;
    nxt_core.req1 = link_ff.reqTgl;
    nxt_core.req2 = core_ff.req1;
    nxt_core.req3 = core_ff.req2;
    if (access && link_ff.wr) begin
      clr = link_ff.wdata;
    end
    for (int s = 0; s < NUM_SLOTS; s++) begin
      // Each flag is set only while its supply is enabled from the register side.
      nxt_core.flg[s].standby = (core_ff.flg[s].standby
                                & ~(clr[`DSP_ST_STANDBY_OC]
                                    && link_ff.cmd == `DSP_CMD_STAT_A + 8'(s)))
                              | (core_ff.in2[s].standbyOc
                                 & core_ff.ctl[s][`DSP_CTL_STANDBY_ON]);
      nxt_core.flg[s].twelve  = (core_ff.flg[s].twelve
                                & ~(clr[`DSP_ST_TWELVE_OC]
                                    && link_ff.cmd == `DSP_CMD_STAT_A + 8'(s)))
                              | (core_ff.in2[s].twelveOc
                                 & core_ff.ctl[s][`DSP_CTL_PRIMARY_ON]);
      nxt_core.flg[s].three   = (core_ff.flg[s].three
                                & ~(clr[`DSP_ST_THREE_OC]
                                    && link_ff.cmd == `DSP_CMD_STAT_A + 8'(s)))
                              | (core_ff.in2[s].threeOc
                                 & core_ff.ctl[s][`DSP_CTL_PRIMARY_ON]);
      // The pin latches clear only when their enable pins drop; status register writes never clear them.
      nxt_core.hpiMain[s] = (core_ff.hpiMain[s]
                             | ((core_ff.in2[s].twelveOc | core_ff.in2[s].threeOc)
                                & ~forced[s]))
                            & core_ff.in2[s].primaryOnPin;
      nxt_core.hpiAux[s]  = (core_ff.hpiAux[s]
                             | (core_ff.in2[s].standbyOc & ~forced[s]))
                            & core_ff.in2[s].standbyEnablePin;
    end
    nxt_core.uvFlag = (core_ff.uvFlag & ~(clr[`DSP_CS_UV] && link_ff.cmd == `DSP_CMD_COMMON))
                    | core_ff.com2[0];
    nxt_core.otFlag = (core_ff.otFlag & ~(clr[`DSP_CS_OT] && link_ff.cmd == `DSP_CMD_COMMON))
                    | core_ff.com2[1];
    if (access) begin
      if (link_ff.wr) begin
        case (link_ff.cmd)
          `DSP_CMD_CTL_A, `DSP_CMD_CTL_B: begin
            k = (link_ff.cmd == `DSP_CMD_CTL_B) ? 1 : 0;
            nxt_core.ctl[k] = link_ff.wdata[2:0];
          end
          `DSP_CMD_COMMON: nxt_core.mask = link_ff.wdata[`DSP_CS_MASK];
          default: nxt_core.mask = core_ff.mask;
        endcase
      end
      nxt_core.rdData = readReg(core_ff, link_ff.cmd, primaryOn, standbyOn, faultActive);
      nxt_core.ackTgl = ~core_ff.ackTgl;
    end
    if (!ce) begin
      nxt_core = core_ff;
    end
    if (srst) begin
      nxt_core = '0;
      // Pin stages start at idle levels: no override, no enable, no overcurrent,
      // and power not yet good, so nothing is switched on or latched by a preset.
      for (int s = 0; s < NUM_SLOTS; s++) begin
        nxt_core.in1[s].overrideOnN = 1'b1;
        nxt_core.in2[s].overrideOnN = 1'b1;
      end
      nxt_core.ctl = '0;
      nxt_core.flg = '0;
      nxt_core.mask = `DSP_CS_MASK_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    core_ff <= nxt_core;
  end

  a_mask_blocks: assert property (@(posedge mclk) disable iff (srst)
    core_ff.mask |-> !attnOe)
    else $error("interrupt active while masked");

  a_w1c_clears: assert property (@(posedge mclk) disable iff (srst)
    (access && link_ff.wr && link_ff.cmd == `DSP_CMD_STAT_A
     && link_ff.wdata[`DSP_ST_TWELVE_OC] && !core_ff.in2[0].twelveOc)
    |=> !core_ff.flg[0].twelve)
    else $error("write one did not clear the flag");

  a_rd_reserved: assert property (@(posedge mclk) disable iff (srst)
    $past(access) && $past(link_ff.cmd) == `DSP_CMD_CTL_A |-> core_ff.rdData[5:3] == 3'h0)
    else $error("reserved control bits read nonzero");

  // --------------------------------------------------------------------------
  // Link side command port
  // --------------------------------------------------------------------------
  // The request fields stay frozen while busy, so the core can sample them
  // after the toggle has passed its synchroniser.
  always_comb begin
    nxt_link = link_ff;
    nxt_link.ack1 = core_ff.ackTgl;
    nxt_link.ack2 = link_ff.ack1;
    nxt_link.ack3 = link_ff.ack2;
    nxt_link.done = 1'b0;
    if (link_ff.busy && (link_ff.ack2 != link_ff.ack3)) begin
      nxt_link.busy  = 1'b0;
      nxt_link.done  = 1'b1;
      nxt_link.rdata = core_ff.rdData;
    end else if (!link_ff.busy && lnkCmdValid) begin
      nxt_link.busy   = 1'b1;
      nxt_link.wr     = lnkWrite;
      nxt_link.cmd    = lnkCmd;
      nxt_link.wdata  = lnkWdata;
      nxt_link.reqTgl = ~link_ff.reqTgl;
    end
    if (lnkRst) begin
      nxt_link = '0;
    end
  end

  always_ff @(posedge lnkClk) begin
    link_ff <= nxt_link;
  end

  assign lnkReady = ~link_ff.busy;
  assign lnkDone  = link_ff.done;
  assign lnkRdata = link_ff.rdata;

  a_link_done: assert property (@(posedge lnkClk) disable iff (lnkRst)
    (lnkCmdValid && lnkReady) |-> ##[6:40] lnkDone)
    else $error("command not answered in time");

  a_link_busy: assert property (@(posedge lnkClk) disable iff (lnkRst)
    (lnkCmdValid && lnkReady) |=> !lnkReady)
    else $error("command port stayed ready after taking a request");

  a_ready_after_done: assert property (@(posedge lnkClk) disable iff (lnkRst)
    lnkDone |-> lnkReady)
    else $error("command port not ready after its answer");

endmodule

// *** verif/dsp_host_model.sv ***
// Host side model of the byte command port: one request outstanding at a time.
// Assumes lnkClk runs freely and the register bank answers each request with lnkDone.
`timescale 1ns/1ns

module dsp_host_model (
  input  wire logic       lnkClk,
  input  wire logic       lnkReady,
  input  wire logic       lnkDone,
  input  wire logic [7:0] lnkRdata,
  output logic            lnkCmdValid,
  output logic            lnkWrite,
  output logic [7:0]      lnkCmd,
  output logic [7:0]      lnkWdata
);
  int gap = 0;

  initial begin
    lnkCmdValid = 1'b0;
    lnkWrite    = 1'b0;
    lnkCmd      = 8'h00;
    lnkWdata    = 8'h00;
  end

  // Code and data are inverted once taken, so a late sample cannot see the old byte.
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd, output bit ok);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    repeat (gap + 1) @(posedge lnkClk);
    lnkCmdValid <= 1'b1;
    lnkWrite    <= wr;
    lnkCmd      <= cmd;
    lnkWdata    <= wd;
    // Ready and done are read at the falling edge, where they have settled.
    while (!seen && n < 100) begin
      @(negedge lnkClk);
      seen = (lnkReady === 1'b1);
      @(posedge lnkClk);
      n++;
    end
    lnkCmdValid <= 1'b0;
    lnkCmd      <= ~cmd;
    lnkWdata    <= ~wd;
    seen = 1'b0;
    while (!seen && n < 100) begin
      @(negedge lnkClk);
      seen = (lnkDone === 1'b1);
      n++;
    end
    rd = lnkRdata;
    ok = seen;
    @(posedge lnkClk);
  endtask
endmodule

// *** verif/dual_slot_power_register_map_bench.sv ***
// Self-checking bench: drives slot pins and the command port, compares with a model.
// Assumes the register bank header and package are on the include and compile paths.
`timescale 1ns/1ns
`include "dsp_cfg.svh"

module dual_slot_power_register_map_bench;
  logic                   mclk = 1'b0, lnkClk = 1'b0, srst = 1'b1, lnkRst = 1'b1;
  logic                   uvEvent = 1'b0, otEvent = 1'b0, attnOut, attnOe;
  logic                   lnkCmdValid, lnkWrite, lnkReady, lnkDone;
  logic [7:0]             lnkCmd, lnkWdata, lnkRdata;
  logic [1:0]             gpiIn = 2'h0;
  dsp_pkg::dsp_slot_in_t  slotIn [2];
  dsp_pkg::dsp_slot_out_t slotOut [2];
  logic [7:0]             pinM [2];
  logic [2:0]             ctlM [2], ocM [2];
  logic                   fltMain [2], fltStby [2];
  logic                   maskM = 1'b0, uvM = 1'b0, otM = 1'b0;
  logic [31:0]            lfsr = 32'h680F;
  int                     errors = 0, n_compared = 0, cyc = 0;

  dsp_regs u_dut (.mclk(mclk), .srst(srst), .ce(1'b1), .lnkClk(lnkClk), .lnkRst(lnkRst),
    .lnkCmdValid(lnkCmdValid), .lnkWrite(lnkWrite), .lnkCmd(lnkCmd), .lnkWdata(lnkWdata),
    .lnkReady(lnkReady), .lnkDone(lnkDone), .lnkRdata(lnkRdata), .slotIn(slotIn),
    .slotOut(slotOut), .uvEvent(uvEvent), .otEvent(otEvent), .gpiIn(gpiIn),
    .attnOut(attnOut), .attnOe(attnOe));

  dsp_host_model u_host (.lnkClk(lnkClk), .lnkReady(lnkReady), .lnkDone(lnkDone),
    .lnkRdata(lnkRdata), .lnkCmdValid(lnkCmdValid), .lnkWrite(lnkWrite), .lnkCmd(lnkCmd),
    .lnkWdata(lnkWdata));

  initial forever #25 mclk = ~mclk;
  initial begin
    #7;
    forever #3 lnkClk = ~lnkClk;
  end

  // --------------------------------------------------------------------------
  // Checking and model
  // --------------------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic forcedM(int s);
    return !pinM[s][5] && !ctlM[s][2];
  endfunction

  function automatic logic onM(int s, bit prim);
    if (forcedM(s)) return 1'b1;
    return prim ? ctlM[s][1] & !ocM[s][1] & !ocM[s][0] : ctlM[s][0] & !ocM[s][2];
  endfunction

  function automatic logic [7:0] expRead(logic [7:0] c);
    int s;
    s = c[0] ? 1 : 0;
    case (c)
      8'h02, 8'h03: return {pinM[s][7:6], 3'h0, ctlM[s]};
      8'h04, 8'h05: return {fltMain[s] | fltStby[s], onM(s, 1), onM(s, 0), ocM[s][2], 1'b0,
                            ocM[s][1], 1'b0, ocM[s][0]};
      8'h06: return {2'h0, gpiIn, maskM, uvM, otM, 1'b0};
      default: return 8'h00;
    endcase
  endfunction

  task automatic rw(input logic wr, input logic [7:0] c, input logic [7:0] d,
                    input logic [7:0] m);
    logic [7:0] rd;
    bit         ok;
    int         s;
    s = c[0] ? 1 : 0;
    u_host.access(wr, c, d, rd, ok);
    check({7'h0, ok}, 8'h01);
    if (!wr) begin
      check(rd & m, expRead(c) & m);
    end else if (c == 8'h02 || c == 8'h03) begin
      ctlM[s] = d[2:0];
    end else if (c == 8'h04 || c == 8'h05) begin
      ocM[s] = ocM[s] & ~{d[4], d[2], d[0]};
    end else if (c == 8'h06) begin
      maskM = d[3];
      uvM   = uvM & !d[2];
      otM   = otM & !d[1];
    end
  endtask

  task automatic checkAll(input bit hpi);
    logic [5:0] e;
    for (int s = 0; s < 2; s++) begin
      e = {onM(s, 0), onM(s, 1), 1'b0, forcedM(s) | !(pinM[s][7] & pinM[s][6]), 1'b0,
           (fltMain[s] | fltStby[s]) & pinM[s][5]};
      check({2'h0, slotOut[s]} & (hpi ? 8'h0F : 8'h3F), {2'h0, e} & (hpi ? 8'h0F : 8'h3F));
    end
    for (int c = 2; c < 7; c++) rw(1'b0, 8'(c), 8'h00, (hpi && c > 3) ? 8'h9F : 8'hFF);
    check({7'h0, attnOe}, {7'h0, ((|ocM[0]) | (|ocM[1]) | uvM | otM) & !maskM});
  endtask

  task automatic setPin(int s, logic [7:0] v);
    @(posedge mclk);
    slotIn[s] <= v;
    pinM[s] = v;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    if (!v[4]) fltMain[s] = 1'b0;
    if (!v[3]) fltStby[s] = 1'b0;
    if (v[5] || ctlM[s][2]) begin
      fltMain[s] = fltMain[s] | (v[4] & (v[1] | v[0]));
      fltStby[s] = fltStby[s] | (v[3] & v[2]);
    end
    ocM[s] = ocM[s] | {v[2] & ctlM[s][0], v[1] & ctlM[s][1], v[0] & ctlM[s][1]};
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    for (int s = 0; s < 2; s++) begin
      slotIn[s] = dsp_pkg::dsp_slot_in_t'(8'hE0);
      pinM[s] = 8'hE0;
      ctlM[s] = 3'h0;
      ocM[s] = 3'h0;
      fltMain[s] = 1'b0;
      fltStby[s] = 1'b0;
    end
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge lnkClk);
    lnkRst <= 1'b0;
    repeat (4) @(posedge mclk);
    checkAll(0);
    rw(1'b1, 8'h07, 8'hFF, 8'hFF);
    rw(1'b0, 8'h07, 8'h00, 8'hFF);
    rw(1'b0, 8'hFF, 8'h00, 8'hFF);
    $display("reset and reserved test done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsrNext(lfsr);
      @(posedge mclk);
      gpiIn <= lfsr[3:2];
      setPin(i % 2, {lfsr[5:4], 6'h20});
      rw(1'b1, 8'(2 + i % 2), {lfsr[15:8]}, 8'hFF);
      checkAll(0);
    end
    $display("control register test done");
    for (int s = 0; s < 2; s++) begin
      rw(1'b1, 8'(2 + s), 8'h00, 8'hFF);
      setPin(s, 8'hC0);
      checkAll(0);
      rw(1'b1, 8'(2 + s), 8'h04, 8'hFF);
      checkAll(0);
      rw(1'b1, 8'(2 + s), 8'h03, 8'hFF);
      setPin(s, 8'hE0);
      checkAll(0);
      setPin(s, 8'hE7);
      checkAll(0);
      setPin(s, 8'hE0);
      rw(1'b1, 8'h06, 8'h08, 8'hFF);
      checkAll(0);
      rw(1'b1, 8'h06, 8'h00, 8'hFF);
      rw(1'b1, 8'(4 + s), 8'h01, 8'hFF);
      checkAll(0);
      rw(1'b1, 8'(4 + s), 8'hFF, 8'hFF);
      rw(1'b1, 8'(2 + s), 8'h00, 8'hFF);
      checkAll(0);
    end
    @(posedge mclk);
    uvEvent <= 1'b1;
    otEvent <= 1'b1;
    repeat (3) @(posedge mclk);
    uvEvent <= 1'b0;
    otEvent <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    uvM = 1'b1;
    otM = 1'b1;
    checkAll(0);
    rw(1'b1, 8'h06, 8'h06, 8'hFF);
    checkAll(0);
    $display("override and overcurrent test done");
    u_host.gap = 3;
    for (int s = 0; s < 2; s++) begin
      setPin(s, 8'hF8);
      setPin(s, 8'hFE);
      checkAll(1);
      setPin(s, 8'hF8);
      rw(1'b1, 8'(4 + s), 8'hFF, 8'hFF);
      checkAll(1);
      setPin(s, 8'hD8);
      checkAll(1);
      setPin(s, 8'hE8);
      checkAll(1);
      setPin(s, 8'hE0);
      checkAll(1);
    end
    $display("fault pin test done");
    close_out();
  end
endmodule
